// >>> logic/phsr_pkg.sv
// constants and types shared by the parallel port status and reset logic
package phsr_pkg;

  // ------------------------------------------------------------
  // port select on the two address pins
  // ------------------------------------------------------------
  localparam logic [1:0] PHSR_ADDR_PORT_A = 2'h0;
  localparam logic [1:0] PHSR_ADDR_PORT_B = 2'h1;
  localparam logic [1:0] PHSR_ADDR_STATUS = 2'h2; // third port, handshake_status_readback
  localparam logic [1:0] PHSR_ADDR_CTRL = 2'h3;

  // ------------------------------------------------------------
  // control word fields
  // ------------------------------------------------------------
  localparam int PHSR_CW_FLAG = 7;     // 1: mode set, 0: single bit set/reset
  localparam int PHSR_CW_A_MODE2 = 6;
  localparam int PHSR_CW_A_MODE1 = 5;
  localparam int PHSR_CW_A_IN = 4;
  localparam int PHSR_CW_CHI_IN = 3;
  localparam int PHSR_CW_B_MODE1 = 2;
  localparam int PHSR_CW_B_IN = 1;
  localparam int PHSR_CW_CLO_IN = 0;
  localparam int PHSR_BSR_SEL_LSB = 1; // bit index sits in bits 3:1
  localparam int PHSR_BSR_VAL = 0;

  // ------------------------------------------------------------
  // third port bit positions used by the handshake
  // ------------------------------------------------------------
  localparam int PHSR_PC_OBF_A = 7;
  localparam int PHSR_PC_ACK_A = 6;
  localparam int PHSR_PC_IBF_A = 5;
  localparam int PHSR_PC_STB_A = 4;
  localparam int PHSR_PC_INTR_A = 3;
  localparam int PHSR_PC_HS_B = 2;     // strobe or acknowledge of group b
  localparam int PHSR_PC_BF_B = 1;
  localparam int PHSR_PC_INTR_B = 0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic PHSR_DIR_IN_RST = 1'b1;   // every port comes up as input
  localparam logic [7:0] PHSR_LATCH_RST = 8'h00;
  localparam logic [7:0] PHSR_CTRL_READ = 8'h00;
  localparam logic PHSR_STROBE_IDLE = 1'b1;  // active-low pins idle high

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int PHSR_CLK_PERIOD_NS = 40;
  localparam int PHSR_PWRON_RESET_US = 50;
  localparam int PHSR_RESET_PULSE_NS = 500;
  localparam int PHSR_RESET_CYCLES =
    (PHSR_RESET_PULSE_NS + PHSR_CLK_PERIOD_NS - 1) / PHSR_CLK_PERIOD_NS;
  localparam logic [7:0] PHSR_RESET_CNT_MAX = 8'(PHSR_RESET_CYCLES);

  typedef enum logic [1:0] {
    PHSR_MODE0 = 2'b00,
    PHSR_MODE1 = 2'b01,
    PHSR_MODE2 = 2'b10
  } phsr_mode_e;

endpackage : phsr_pkg

// >>> logic/phsr_sync.sv
// two flip-flop synchroniser bank for every pin entering the core clock
`timescale 1ns/1ps
module phsr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // the first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : phsr_sync

// >>> logic/phsr_top.sv
// programmable parallel port with handshake status readback and reset handling
`timescale 1ns/1ps
module phsr_top
  import phsr_pkg::*;
#(
  parameter bit FAST_VARIANT = 1'b1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic port_reset,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  input wire logic [7:0] pc_in,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [37:0] sync_q;
  logic rst_s, cs_n_s, rd_n_s, wr_n_s;
  logic [1:0] addr_s;
  logic [7:0] dat_s, pa_s, pb_s, pc_s;

  phsr_sync #(.WIDTH(38), .RST_VAL({1'b0, 3'b111, 34'h0ff})) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in({port_reset, cs_n, rd_n, wr_n, addr, data_in, pa_in, pb_in, pc_in}),
    .sync_out(sync_q)
  );

  assign {rst_s, cs_n_s, rd_n_s, wr_n_s, addr_s, dat_s, pa_s, pb_s, pc_s} = sync_q;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  phsr_mode_e mode_a_q, mode_a_d;
  logic mode_b_q, mode_b_d, a_in_q, a_in_d, b_in_q, b_in_d;
  logic chi_in_q, chi_in_d, clo_in_q, clo_in_d;
  logic [7:0] pa_lat_q, pa_lat_d, pb_lat_q, pb_lat_d, pc_lat_q, pc_lat_d;
  logic [7:0] pa_inl_q, pa_inl_d, pb_inl_q, pb_inl_d, rd_data_q, rd_data_d;
  logic ibf_a_q, ibf_a_d, obf_a_q, obf_a_d, intr_a_q, intr_a_d;
  logic inte_a_q, inte_a_d, out_irq_enable_bidir_q, out_irq_enable_bidir_d, in_irq_enable_bidir_q, in_irq_enable_bidir_d;
  logic ibf_b_q, ibf_b_d, obf_b_q, obf_b_d, intr_b_q, intr_b_d, inte_b_q, inte_b_d;
  logic rd_act_q, rd_act_d, rd_prev_q, wr_prev_q, stba_prev_q, acka_prev_q, hsb_prev_q;
  logic [1:0] rd_addr_q, rd_addr_d;
  logic [7:0] rst_cnt_q, rst_cnt_d;

  // ------------------------------------------------------------
  // decode of modes and edges
  // ------------------------------------------------------------
  logic a_m1in, a_m1out, a_m2, a_in_hs, a_out_hs, b_m1in, b_m1out;
  logic wr_rise, rd_fall, rd_rise, soft_rst;
  logic stba_fall, stba_rise, acka_fall, acka_rise, hsb_fall, hsb_rise;
  logic [7:0] hs_mask, hs_out_mask, hs_val, pc_m0, pc_rb, pa_rd, pb_rd;
  logic [2:0] bsr_sel;

  assign a_m1in = (mode_a_q == PHSR_MODE1) && a_in_q;
  assign a_m1out = (mode_a_q == PHSR_MODE1) && !a_in_q;
  assign a_m2 = (mode_a_q == PHSR_MODE2);
  assign a_in_hs = a_m1in || a_m2;
  assign a_out_hs = a_m1out || a_m2;
  assign b_m1in = mode_b_q && b_in_q;
  assign b_m1out = mode_b_q && !b_in_q;

  assign wr_rise = !wr_prev_q && wr_n_s && !cs_n_s;
  assign rd_fall = rd_prev_q && !rd_n_s && !cs_n_s;
  assign rd_rise = !rd_prev_q && rd_n_s && rd_act_q;
  assign stba_fall = stba_prev_q && !pc_s[PHSR_PC_STB_A];
  assign stba_rise = !stba_prev_q && pc_s[PHSR_PC_STB_A];
  assign acka_fall = acka_prev_q && !pc_s[PHSR_PC_ACK_A];
  assign acka_rise = !acka_prev_q && pc_s[PHSR_PC_ACK_A];
  assign hsb_fall = hsb_prev_q && !pc_s[PHSR_PC_HS_B];
  assign hsb_rise = !hsb_prev_q && pc_s[PHSR_PC_HS_B];
  assign soft_rst = (rst_cnt_q == PHSR_RESET_CNT_MAX);
  assign bsr_sel = dat_s[PHSR_BSR_SEL_LSB +: 3];

  // ------------------------------------------------------------
  // third port: handshake masks, drive values and readback
  // ------------------------------------------------------------
  always_comb begin
    hs_mask = 8'h00;
    hs_out_mask = 8'h00;
    if (a_in_hs) begin
      hs_mask = hs_mask | 8'h38;      // strobe in, full and request out
      hs_out_mask = hs_out_mask | 8'h28;
    end
    if (a_out_hs) begin
      hs_mask = hs_mask | 8'hc8;      // ack in, full and request out
      hs_out_mask = hs_out_mask | 8'h88;
    end
    if (mode_b_q) begin
      hs_mask = hs_mask | 8'h07;
      hs_out_mask = hs_out_mask | 8'h03;
    end
    // pin levels: output-full lines are active low
    hs_val = 8'h00;
    hs_val[PHSR_PC_OBF_A] = !obf_a_q;
    hs_val[PHSR_PC_IBF_A] = ibf_a_q;
    hs_val[PHSR_PC_INTR_A] = intr_a_q;
    hs_val[PHSR_PC_BF_B] = b_in_q ? ibf_b_q : !obf_b_q;
    hs_val[PHSR_PC_INTR_B] = intr_b_q;
    // free bits behave as plain mode 0 input or output
    pc_m0 = {chi_in_q ? pc_s[7:4] : pc_lat_q[7:4], clo_in_q ? pc_s[3:0] : pc_lat_q[3:0]};
    pc_rb = pc_m0;
    // the status word replaces pin values on handshake bits
    if (a_in_hs || a_out_hs) begin
      pc_rb[PHSR_PC_INTR_A] = intr_a_q;
    end
    if (a_m1in) begin
      pc_rb[PHSR_PC_IBF_A] = ibf_a_q;
      pc_rb[PHSR_PC_STB_A] = inte_a_q;
    end
    if (a_m1out) begin
      pc_rb[PHSR_PC_OBF_A] = !obf_a_q;
      pc_rb[PHSR_PC_ACK_A] = inte_a_q;
    end
    if (a_m2) begin
      pc_rb[PHSR_PC_OBF_A] = !obf_a_q;
      pc_rb[PHSR_PC_ACK_A] = out_irq_enable_bidir_q;
      pc_rb[PHSR_PC_IBF_A] = ibf_a_q;
      pc_rb[PHSR_PC_STB_A] = in_irq_enable_bidir_q;
    end
    if (mode_b_q) begin
      pc_rb[PHSR_PC_HS_B] = inte_b_q;
      pc_rb[PHSR_PC_BF_B] = hs_val[PHSR_PC_BF_B];
      pc_rb[PHSR_PC_INTR_B] = intr_b_q;
    end
    pa_rd = a_in_hs ? pa_inl_q : ((a_in_q && !a_m1out) ? pa_s : pa_lat_q);
    pb_rd = b_m1in ? pb_inl_q : (b_in_q ? pb_s : pb_lat_q);
  end

  assign pc_out = (hs_out_mask & hs_val) | (~hs_out_mask & pc_lat_q);
  assign pc_oe = hs_out_mask | (~hs_mask & {{4{!chi_in_q}}, {4{!clo_in_q}}});
  assign pa_out = pa_lat_q;
  // mode 2 only drives port a while the peripheral acknowledges
  assign pa_oe = {8{(mode_a_q == PHSR_MODE0 && !a_in_q) || a_m1out
                    || (a_m2 && !pc_s[PHSR_PC_ACK_A])}};
  assign pb_out = pb_lat_q;
  assign pb_oe = {8{!b_in_q}};
  assign data_out = rd_data_q;
  assign data_oe = rd_act_q;

  // ------------------------------------------------------------
  // next-state logic: clears first, hardware sets after, reset last
  // ------------------------------------------------------------
  always_comb begin
    mode_a_d = mode_a_q;
    mode_b_d = mode_b_q;
    a_in_d = a_in_q;
    b_in_d = b_in_q;
    chi_in_d = chi_in_q;
    clo_in_d = clo_in_q;
    pa_lat_d = pa_lat_q;
    pb_lat_d = pb_lat_q;
    pc_lat_d = pc_lat_q;
    pa_inl_d = pa_inl_q;
    pb_inl_d = pb_inl_q;
    rd_data_d = rd_data_q;
    ibf_a_d = ibf_a_q;
    obf_a_d = obf_a_q;
    intr_a_d = intr_a_q;
    inte_a_d = inte_a_q;
    out_irq_enable_bidir_d = out_irq_enable_bidir_q;
    in_irq_enable_bidir_d = in_irq_enable_bidir_q;
    ibf_b_d = ibf_b_q;
    obf_b_d = obf_b_q;
    intr_b_d = intr_b_q;
    inte_b_d = inte_b_q;
    rd_act_d = rd_act_q && !rd_n_s;
    rd_addr_d = rd_addr_q;
    rst_cnt_d = !rst_s ? 8'h00 : (soft_rst ? rst_cnt_q : rst_cnt_q + 8'h01);
    // acknowledge releases output-full ahead of cpu writes, so a same-cycle write wins
    if (a_out_hs && acka_fall) obf_a_d = 1'b0;
    if (b_m1out && hsb_fall) obf_b_d = 1'b0;
    // cpu writes act on the rising edge of the write strobe
    if (wr_rise) begin
      case (addr_s)
        PHSR_ADDR_PORT_A: begin
          pa_lat_d = dat_s;
          if (a_out_hs) begin
            obf_a_d = 1'b1;
            intr_a_d = 1'b0;
          end
        end
        PHSR_ADDR_PORT_B: begin
          pb_lat_d = dat_s;
          if (b_m1out) begin
            obf_b_d = 1'b1;
            intr_b_d = 1'b0;
          end
        end
        PHSR_ADDR_STATUS: begin
          pc_lat_d = dat_s;
        end
        default: begin
          if (dat_s[PHSR_CW_FLAG]) begin
            mode_a_d = dat_s[PHSR_CW_A_MODE2] ? PHSR_MODE2 :
                       (dat_s[PHSR_CW_A_MODE1] ? PHSR_MODE1 : PHSR_MODE0);
            a_in_d = dat_s[PHSR_CW_A_IN];
            chi_in_d = dat_s[PHSR_CW_CHI_IN];
            mode_b_d = dat_s[PHSR_CW_B_MODE1];
            b_in_d = dat_s[PHSR_CW_B_IN];
            clo_in_d = dat_s[PHSR_CW_CLO_IN];
            pa_lat_d = PHSR_LATCH_RST;
            pc_lat_d = PHSR_LATCH_RST;
            // the slow variant keeps stale port b data until written
            if (FAST_VARIANT) begin
              pb_lat_d = PHSR_LATCH_RST;
            end
            {ibf_a_d, obf_a_d, intr_a_d, inte_a_d, out_irq_enable_bidir_d, in_irq_enable_bidir_d} = 6'h00;
            {ibf_b_d, obf_b_d, intr_b_d, inte_b_d} = 4'h0;
          end else begin
            pc_lat_d[bsr_sel] = dat_s[PHSR_BSR_VAL];
            if ((a_m1in && bsr_sel == 3'(PHSR_PC_STB_A))
                || (a_m1out && bsr_sel == 3'(PHSR_PC_ACK_A))) begin
              inte_a_d = dat_s[PHSR_BSR_VAL];
            end
            if (a_m2 && bsr_sel == 3'(PHSR_PC_ACK_A)) begin
              out_irq_enable_bidir_d = dat_s[PHSR_BSR_VAL];
            end
            if (a_m2 && bsr_sel == 3'(PHSR_PC_STB_A)) begin
              in_irq_enable_bidir_d = dat_s[PHSR_BSR_VAL];
            end
            if (mode_b_q && bsr_sel == 3'(PHSR_PC_HS_B)) begin
              inte_b_d = dat_s[PHSR_BSR_VAL];
            end
          end
        end
      endcase
    end
    // cpu reads: data captured at the falling edge of the read strobe
    if (rd_fall) begin
      rd_act_d = 1'b1;
      rd_addr_d = addr_s;
      case (addr_s)
        PHSR_ADDR_PORT_A: begin
          rd_data_d = pa_rd;
          if (a_in_hs) intr_a_d = 1'b0;
        end
        PHSR_ADDR_PORT_B: begin
          rd_data_d = pb_rd;
          if (b_m1in) intr_b_d = 1'b0;
        end
        PHSR_ADDR_STATUS: rd_data_d = pc_rb;
        default: rd_data_d = PHSR_CTRL_READ;
      endcase
    end
    if (rd_rise && rd_addr_q == PHSR_ADDR_PORT_A && a_in_hs) ibf_a_d = 1'b0;
    if (rd_rise && rd_addr_q == PHSR_ADDR_PORT_B && b_m1in) ibf_b_d = 1'b0;
    // peripheral strobes and acknowledges; a set beats a clear
    if (a_in_hs && stba_fall) begin
      pa_inl_d = pa_s;
      ibf_a_d = 1'b1;
    end
    if (a_in_hs && stba_rise && ibf_a_q && (a_m2 ? in_irq_enable_bidir_q : inte_a_q)) intr_a_d = 1'b1;
    if (a_out_hs && acka_rise && !obf_a_q && (a_m2 ? out_irq_enable_bidir_q : inte_a_q)) intr_a_d = 1'b1;
    if (b_m1in && hsb_fall) begin
      pb_inl_d = pb_s;
      ibf_b_d = 1'b1;
    end
    if (b_m1in && hsb_rise && ibf_b_q && inte_b_q) intr_b_d = 1'b1;
    if (b_m1out && hsb_rise && !obf_b_q && inte_b_q) intr_b_d = 1'b1;
    // a long reset pulse puts every port back to input mode
    if (soft_rst) begin
      mode_a_d = PHSR_MODE0;
      mode_b_d = 1'b0;
      {a_in_d, b_in_d, chi_in_d, clo_in_d} = {4{PHSR_DIR_IN_RST}};
      {pa_lat_d, pb_lat_d, pc_lat_d} = {3{PHSR_LATCH_RST}};
      {ibf_a_d, obf_a_d, intr_a_d, inte_a_d, out_irq_enable_bidir_d, in_irq_enable_bidir_d} = 6'h00;
      {ibf_b_d, obf_b_d, intr_b_d, inte_b_d} = 4'h0;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_a_q <= PHSR_MODE0;
      {mode_b_q, a_in_q, b_in_q} <= {1'b0, PHSR_DIR_IN_RST, PHSR_DIR_IN_RST};
      {chi_in_q, clo_in_q} <= {PHSR_DIR_IN_RST, PHSR_DIR_IN_RST};
      {pa_lat_q, pb_lat_q, pc_lat_q} <= {3{PHSR_LATCH_RST}};
      {pa_inl_q, pb_inl_q, rd_data_q} <= {3{PHSR_LATCH_RST}};
      {ibf_a_q, obf_a_q, intr_a_q, inte_a_q, out_irq_enable_bidir_q, in_irq_enable_bidir_q} <= 6'h00;
      {ibf_b_q, obf_b_q, intr_b_q, inte_b_q} <= 4'h0;
      {rd_act_q, rd_addr_q} <= 3'h0;
      {rd_prev_q, wr_prev_q} <= {2{PHSR_STROBE_IDLE}};
      {stba_prev_q, acka_prev_q, hsb_prev_q} <= {3{PHSR_STROBE_IDLE}};
      rst_cnt_q <= 8'h00;
    end else begin
      mode_a_q <= mode_a_d;
      {mode_b_q, a_in_q, b_in_q} <= {mode_b_d, a_in_d, b_in_d};
      {chi_in_q, clo_in_q} <= {chi_in_d, clo_in_d};
      {pa_lat_q, pb_lat_q, pc_lat_q} <= {pa_lat_d, pb_lat_d, pc_lat_d};
      {pa_inl_q, pb_inl_q, rd_data_q} <= {pa_inl_d, pb_inl_d, rd_data_d};
      {ibf_a_q, obf_a_q, intr_a_q, inte_a_q, out_irq_enable_bidir_q, in_irq_enable_bidir_q} <=
        {ibf_a_d, obf_a_d, intr_a_d, inte_a_d, out_irq_enable_bidir_d, in_irq_enable_bidir_d};
      {ibf_b_q, obf_b_q, intr_b_q, inte_b_q} <= {ibf_b_d, obf_b_d, intr_b_d, inte_b_d};
      {rd_act_q, rd_addr_q} <= {rd_act_d, rd_addr_d};
      {rd_prev_q, wr_prev_q} <= {rd_n_s, wr_n_s};
      {stba_prev_q, acka_prev_q, hsb_prev_q} <=
        {pc_s[PHSR_PC_STB_A], pc_s[PHSR_PC_ACK_A], pc_s[PHSR_PC_HS_B]};
      rst_cnt_q <= rst_cnt_d;
    end
  end

endmodule : phsr_top

// >>> testbench/phsr_sva.sv
// checker for the parallel port pins, bus and handshake flags
`timescale 1ns/1ps
module phsr_sva
  import phsr_pkg::*;
#(
  parameter bit FAST_VARIANT = 1'b1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic port_reset,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic [7:0] pa_in,
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pb_in,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe,
  input wire logic [7:0] pc_in,
  input wire logic [7:0] pc_out,
  input wire logic [7:0] pc_oe
);
  // ----------------------------------------
  // length of the running port_reset pulse
  // ----------------------------------------
  logic [4:0] prst_cnt_q;
  logic [4:0] prst_cnt_d;
  // saturates so a very long pulse keeps counting as long
  always_comb begin
    prst_cnt_d = prst_cnt_q;
    if (!port_reset) prst_cnt_d = 5'h00;
    else if (prst_cnt_q != 5'h1f) prst_cnt_d = prst_cnt_q + 5'h01;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) prst_cnt_q <= 5'h00;
    else prst_cnt_q <= prst_cnt_d;
  end

  a_rst_all_input: assert property (@(posedge core_clk) !reset_n |->
    pa_oe == 8'h00 && pb_oe == 8'h00 && pc_oe == 8'h00 && !data_oe)
    else $error("ports drive during system reset");
  // 13 synced cycles plus two sync flops, with margin
  a_long_pulse_input: assert property (@(posedge core_clk) disable iff (!reset_n)
    prst_cnt_q >= 5'h12 |-> pa_oe == 8'h00 && pb_oe == 8'h00 && pc_oe == 8'h00)
    else $error("long port reset pulse left a port driving");
  a_read_oe_drop: assert property (@(posedge core_clk) disable iff (!reset_n)
    rd_n [*5] |-> !data_oe)
    else $error("data bus driven without a read");
  a_in_full_set: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(pc_out[PHSR_PC_IBF_A]) && pc_oe[PHSR_PC_IBF_A] && !pc_oe[PHSR_PC_STB_A]
    |-> !$past(pc_in[PHSR_PC_STB_A], 2))
    else $error("input full set without strobe");
  a_in_full_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    ((rd_n && wr_n && !port_reset) [*6] ##0
    (pc_oe[PHSR_PC_IBF_A] && !pc_oe[PHSR_PC_STB_A] && pc_out[PHSR_PC_IBF_A]))
    |=> pc_out[PHSR_PC_IBF_A])
    else $error("input full dropped without a read");
  a_out_full_set: assert property (@(posedge core_clk) disable iff (!reset_n)
    $fell(pc_out[PHSR_PC_OBF_A]) && pc_oe[PHSR_PC_OBF_A] && !pc_oe[PHSR_PC_ACK_A]
    |-> !$past(wr_n, 4) || !$past(wr_n, 5))
    else $error("output full asserted without a write");
  a_out_full_free: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(pc_out[PHSR_PC_OBF_A]) && pc_oe[PHSR_PC_OBF_A] && !pc_oe[PHSR_PC_ACK_A]
    |-> !$past(pc_in[PHSR_PC_ACK_A], 2) || !$past(wr_n, 4) || !$past(wr_n, 5))
    else $error("output full released without acknowledge");
  a_b_latch_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    $changed(pb_oe) && FAST_VARIANT |-> pb_out == 8'h00)
    else $error("port b latch not cleared on mode change");
endmodule : phsr_sva

bind phsr_top phsr_sva #(.FAST_VARIANT(FAST_VARIANT)) u_sva (
  .core_clk(core_clk), .reset_n(reset_n), .port_reset(port_reset), .cs_n(cs_n),
  .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
  .data_oe(data_oe), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in),
  .pb_out(pb_out), .pb_oe(pb_oe), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe)
);

// >>> testbench/phsr_periph.sv
// strobed peripheral model on the three parallel ports
`timescale 1ns/1ps
module phsr_periph (
  input wire logic core_clk,
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe,
  input wire logic [7:0] pc_out,
  input wire logic [7:0] pc_oe,
  output logic [7:0] pa_in,
  output logic [7:0] pb_in,
  output logic [7:0] pc_in
);
  // ----------------------------------------
  // pin levels
  // ----------------------------------------
  logic [7:0] noise_q = 8'h00;
  logic [7:0] pa_val = 8'h00;
  logic pa_en = 1'b0;
  logic [2:0] hs_n = 3'h7; // {b strobe/ack, a ack, a strobe}, idle high
  // released lines keep changing so stale data never looks valid
  always @(posedge core_clk) noise_q <= noise_q + 8'h35;
  assign pa_in = (pa_oe != 8'h00) ? pa_out : (pa_en ? pa_val : noise_q);
  assign pb_in = (pb_oe != 8'h00) ? pb_out : noise_q;
  // handshake inputs only where the block does not drive
  always_comb begin
    pc_in = (pc_out & pc_oe) | (noise_q & ~pc_oe);
    if (!pc_oe[4]) pc_in[4] = hs_n[0];
    if (!pc_oe[6]) pc_in[6] = hs_n[1];
    if (!pc_oe[2]) pc_in[2] = hs_n[2];
  end
  // low pulse on one handshake line, then a quiet gap
  task automatic pulse(input int idx, input int len);
    @(negedge core_clk);
    hs_n[idx] = 1'b0;
    repeat (len) @(negedge core_clk);
    hs_n[idx] = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask : pulse
  // data stays put across the strobe rise
  task automatic strobe_a(input logic [7:0] v);
    pa_val = v;
    pa_en = 1'b1;
    pulse(0, 6);
    pa_en = 1'b0;
  endtask : strobe_a
endmodule : phsr_periph

// >>> testbench/phsr_top_tb.sv
// self-checking bench for the parallel port status and reset logic
`timescale 1ns/1ps
module phsr_top_tb;
  import phsr_pkg::*;
  logic core_clk, reset_n, port_reset, cs_n, rd_n, wr_n, data_oe;
  logic [1:0] addr;
  logic [7:0] data_in, data_out, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
  logic [7:0] pc_in, pc_out, pc_oe;
  logic [7:0] slow_pa_out, slow_pb_out;
  int fail_count = 0;
  int total_checks = 0;

  phsr_top #(.FAST_VARIANT(1'b1)) u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .port_reset(port_reset), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in),
    .pb_out(pb_out), .pb_oe(pb_oe), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe));
  // slow variant on the same pins; only its port a and b latches are compared
  phsr_top #(.FAST_VARIANT(1'b0)) u_dut_slow (
    .core_clk(core_clk), .reset_n(reset_n), .port_reset(port_reset), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(),
    .data_oe(), .pa_in(pa_in), .pa_out(slow_pa_out), .pa_oe(), .pb_in(pb_in),
    .pb_out(slow_pb_out), .pb_oe(), .pc_in(pc_in), .pc_out(), .pc_oe());
  phsr_periph u_per (
    .core_clk(core_clk), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out),
    .pb_oe(pb_oe), .pc_out(pc_out), .pc_oe(pc_oe), .pa_in(pa_in), .pb_in(pb_in),
    .pc_in(pc_in));

  always #20 core_clk = ~core_clk;

  // ----------------------------------------
  // compare, verdict and bus tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // write strobe held four cycles each side, read strobe low until data_oe then high four, past the two sync flops
  task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge core_clk);
    cs_n = 1'b0;
    addr = a;
    data_in = d;
    wr_n = 1'b0;
    repeat (4) @(negedge core_clk);
    wr_n = 1'b1;
    repeat (4) @(negedge core_clk);
    cs_n = 1'b1;
  endtask : bus_wr
  task automatic rd_check(input logic [1:0] a, input string name, input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge core_clk);
    cs_n = 1'b0;
    addr = a;
    rd_n = 1'b0;
    while (data_oe !== 1'b1 && n < 10) begin
      @(negedge core_clk);
      n++;
    end
    if (data_oe !== 1'b1) begin
      fail_count++;
      end_of_test();
    end
    check(name, data_out, exp);
    rd_n = 1'b1;
    repeat (4) @(negedge core_clk);
    cs_n = 1'b1;
  endtask : rd_check

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    reset_n = 1'b1;
    // a clean falling edge so the async reset lands before the first clock edge
    #1;
    reset_n = 1'b0;
    port_reset = 1'b1; // held over 50 us at power-on
    {cs_n, rd_n, wr_n} = 3'h7;
    addr = 2'h0;
    data_in = 8'h00;
    repeat (5) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (1300) @(negedge core_clk);
    check("pa_oe", pa_oe, 8'h00);
    port_reset = 1'b0;
    repeat (3) @(negedge core_clk);
    // mode 0 outputs, then a control write clears the latches, except port b on the slow variant
    bus_wr(PHSR_ADDR_CTRL, 8'h80);
    bus_wr(PHSR_ADDR_PORT_A, 8'h5a);
    bus_wr(PHSR_ADDR_PORT_B, 8'ha5);
    bus_wr(PHSR_ADDR_STATUS, 8'h3c);
    check("pa_out", pa_out, 8'h5a);
    check("pb_out", pb_out, 8'ha5);
    check("pc_out", pc_out, 8'h3c);
    bus_wr(PHSR_ADDR_CTRL, 8'h80);
    check("pa_out", pa_out, 8'h00);
    check("pc_out", pc_out, 8'h00);
    check("pb_out", pb_out, 8'h00);
    check("slow_pa_out", slow_pa_out, 8'h00);
    check("slow_pb_out", slow_pb_out, 8'ha5);
    // a mode 1 input, b mode 1 output, upper c spare outputs
    bus_wr(PHSR_ADDR_CTRL, 8'hb4);
    bus_wr(PHSR_ADDR_CTRL, 8'h09);
    bus_wr(PHSR_ADDR_CTRL, 8'h05);
    bus_wr(PHSR_ADDR_CTRL, 8'h0f);
    u_per.strobe_a(8'h3e);
    rd_check(PHSR_ADDR_STATUS, "stat_a_in", 8'hbe);
    rd_check(PHSR_ADDR_PORT_A, "port_a", 8'h3e);
    rd_check(PHSR_ADDR_STATUS, "stat_a_rd", 8'h96);
    bus_wr(PHSR_ADDR_PORT_B, 8'h77);
    check("pb_out", pb_out, 8'h77);
    rd_check(PHSR_ADDR_STATUS, "stat_b_full", 8'h94);
    u_per.pulse(2, 3);
    rd_check(PHSR_ADDR_STATUS, "stat_b_ack", 8'h97);
    // a mode 1 output, b mode 1 input
    bus_wr(PHSR_ADDR_CTRL, 8'ha6);
    bus_wr(PHSR_ADDR_CTRL, 8'h0d);
    rd_check(PHSR_ADDR_STATUS, "stat_a_out", 8'hc0);
    bus_wr(PHSR_ADDR_PORT_A, 8'h11);
    rd_check(PHSR_ADDR_STATUS, "stat_a_full", 8'h40);
    u_per.pulse(1, 8);
    rd_check(PHSR_ADDR_STATUS, "stat_a_ack", 8'hc8);
    u_per.pulse(2, 4);
    rd_check(PHSR_ADDR_STATUS, "stat_b_in", 8'hca);
    // a bidirectional, both interrupt enables set
    bus_wr(PHSR_ADDR_CTRL, 8'hc0);
    bus_wr(PHSR_ADDR_CTRL, 8'h0d);
    bus_wr(PHSR_ADDR_CTRL, 8'h09);
    rd_check(PHSR_ADDR_STATUS, "stat_bi", 8'hd0);
    bus_wr(PHSR_ADDR_PORT_A, 8'h69);
    rd_check(PHSR_ADDR_STATUS, "stat_bi_out", 8'h50);
    u_per.strobe_a(8'h96);
    rd_check(PHSR_ADDR_STATUS, "stat_bi_in", 8'h78);
    // short port reset pulse is ignored, a long one forces input mode
    port_reset = 1'b1;
    repeat (6) @(negedge core_clk);
    port_reset = 1'b0;
    repeat (4) @(negedge core_clk);
    check("pb_oe", pb_oe, 8'hff);
    port_reset = 1'b1;
    repeat (24) @(negedge core_clk);
    check("pb_oe", pb_oe, 8'h00);
    check("pc_oe", pc_oe, 8'h00);
    port_reset = 1'b0;
    end_of_test();
  end
endmodule : phsr_top_tb
